// ===== design/timer_run_flags.v
/*
  Upper half of the timer control register: run bits and overflow flags
  for timers 0 and 1, plus the timer status toggle-output enables.
  Assumes overflow and vector strobes are one-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
`include "timer_run_flags_consts.vh"

module timer_run_flags (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  input  wire        timer0_overflow_i,
  input  wire        timer1_overflow_i,
  input  wire        timer0_vector_i,
  output reg         timer0_run_o,
  output reg         timer1_run_o,
  output reg         timer0_overflow_flag_o,
  output reg         timer1_overflow_flag_o,
  output reg         timer0_toggle_out_enable_o,
  output reg         timer1_toggle_out_enable_o
);

  reg  [7:0] timer_control_r;
  reg  [7:0] timer_status_r;
  wire       req;
  wire       hit_ctl;
  wire       hit_sts;
  wire       wr_ctl;
  wire       wr_sts;
  reg        t0_flag_nxt;
  reg        t1_flag_nxt;

  // Ack gap: one answer per request, dropped the cycle after
  assign req     = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_ctl = (adr_i == `TCTL_OFFSET);
  assign hit_sts = (adr_i == `TSTS_OFFSET);
  assign wr_ctl  = req & we_i & hit_ctl & sel_i[0];
  assign wr_sts  = req & we_i & hit_sts & sel_i[0];

  // Hardware set wins over a software clear in the same cycle
  always @* begin
    t1_flag_nxt = timer_control_r[`TCTL_T1_FLAG];
    if (wr_ctl) begin
      t1_flag_nxt = dat_i[`TCTL_T1_FLAG];
    end
    if (timer1_overflow_i && !timer_status_r[`TSTS_T1_TOE]) begin
      t1_flag_nxt = 1'b1;
    end
    t0_flag_nxt = timer_control_r[`TCTL_T0_FLAG];
    if (wr_ctl) begin
      t0_flag_nxt = dat_i[`TCTL_T0_FLAG];
    end
    if (timer0_vector_i) begin
      t0_flag_nxt = 1'b0;
    end
    if (timer0_overflow_i && !timer_status_r[`TSTS_T0_TOE]) begin
      t0_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_r <= `TCTL_RESET;
      timer_status_r  <= `TSTS_RESET;
      ack_o           <= 1'b0;
      err_o           <= 1'b0;
      dat_o           <= 32'h00000000;
    end else begin
      timer_control_r[`TCTL_T1_FLAG] <= t1_flag_nxt;
      timer_control_r[`TCTL_T0_FLAG] <= t0_flag_nxt;
      if (wr_ctl) begin
        timer_control_r[`TCTL_T1_RUN] <= dat_i[`TCTL_T1_RUN];
        timer_control_r[`TCTL_T0_RUN] <= dat_i[`TCTL_T0_RUN];
      end
      if (wr_sts) begin
        timer_status_r[`TSTS_T1_TOE] <= dat_i[`TSTS_T1_TOE];
        timer_status_r[`TSTS_T0_TOE] <= dat_i[`TSTS_T0_TOE];
      end
      ack_o <= req & (hit_ctl | hit_sts);
      err_o <= req & ~(hit_ctl | hit_sts);
      if (req & ~we_i & hit_ctl) begin
        dat_o <= {24'h000000, timer_control_r[7:4], 4'h0};
      end else if (req & ~we_i & hit_sts) begin
        dat_o <= {24'h000000, timer_status_r};
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  // Outputs registered; mirror the register a cycle late
  always @(posedge clk_i) begin
    if (rst_i) begin
      timer0_run_o               <= 1'b0;
      timer1_run_o               <= 1'b0;
      timer0_overflow_flag_o     <= 1'b0;
      timer1_overflow_flag_o     <= 1'b0;
      timer0_toggle_out_enable_o <= 1'b0;
      timer1_toggle_out_enable_o <= 1'b0;
    end else begin
      timer0_run_o               <= timer_control_r[`TCTL_T0_RUN];
      timer1_run_o               <= timer_control_r[`TCTL_T1_RUN];
      timer0_overflow_flag_o     <= timer_control_r[`TCTL_T0_FLAG];
      timer1_overflow_flag_o     <= timer_control_r[`TCTL_T1_FLAG];
      timer0_toggle_out_enable_o <= timer_status_r[`TSTS_T0_TOE];
      timer1_toggle_out_enable_o <= timer_status_r[`TSTS_T1_TOE];
    end
  end

endmodule

// ===== design/timer_run_flags_consts.vh
/*
  Constants for the timer run and overflow flag block: register offsets,
  bit positions, reset values.
  Assumes a classic Wishbone slave with 32-bit data, byte addresses.
*/
`ifndef TIMER_RUN_FLAGS_CONSTS_VH
`define TIMER_RUN_FLAGS_CONSTS_VH

`define TCTL_OFFSET     4'h0
`define TSTS_OFFSET     4'h4
`define ADDR_W          4
`define TCTL_T1_FLAG    7
`define TCTL_T1_RUN     6
`define TCTL_T0_FLAG    5
`define TCTL_T0_RUN     4
`define TSTS_T1_TOE     2
`define TSTS_T0_TOE     0
`define TCTL_RESET      8'h00
`define TSTS_RESET      8'h00

`endif

// ===== tb/timer_run_flags_sva.sv
/* Checks on the timer_run_flags ports. Assumes one clock. */
`timescale 1ns/1ps
module timer_run_flags_sva (input logic clk_i, rst_i, we_i, ack_o, timer0_overflow_i, timer0_vector_i,
  timer0_run_o, timer1_run_o, timer0_overflow_flag_o, timer0_toggle_out_enable_o, timer1_overflow_i,
  timer1_overflow_flag_o, timer1_toggle_out_enable_o, input logic [3:0] adr_i, sel_i,
  input logic [31:0] dat_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire w0 = ack_o && we_i && adr_i == 4'h0 && sel_i[0];
  a_t0_mask: assert property (
    timer0_overflow_i && timer0_toggle_out_enable_o && !timer0_overflow_flag_o && !ack_o |=> ##1 !timer0_overflow_flag_o)
    else $error("mask");
  a_t0_clear: assert property (
    timer0_vector_i && !timer0_overflow_i |=> ##1 !timer0_overflow_flag_o) else $error("clear");
  a_run_write: assert property (
    w0 |=> {timer1_run_o, timer0_run_o} == $past({dat_i[6], dat_i[4]})) else $error("run");
  a_t0_set: assert property (
    timer0_overflow_i && !timer0_toggle_out_enable_o && !ack_o |=> ##1 timer0_overflow_flag_o) else $error("t0 set");
  a_t1_set: assert property (
    timer1_overflow_i && !timer1_toggle_out_enable_o && !ack_o |=> ##1 timer1_overflow_flag_o) else $error("t1 set");
  a_t1_mask: assert property (
    timer1_overflow_i && timer1_toggle_out_enable_o && !timer1_overflow_flag_o && !ack_o |=> ##1 !timer1_overflow_flag_o)
    else $error("t1 mask");
  cover property (w0);
  cover property (timer0_vector_i);
  cover property (timer0_overflow_i && timer0_toggle_out_enable_o);
endmodule
bind timer_run_flags timer_run_flags_sva i_sva (.*);

// ===== tb/tb.sv
/* Bench: bus cycles and timer strobes. Assumes one-cycle acks. */
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, err_o, timer0_run_o, timer1_run_o;
  logic timer0_overflow_i = 0, timer1_overflow_i = 0, timer0_vector_i = 0, timer0_overflow_flag_o;
  logic timer1_overflow_flag_o, timer0_toggle_out_enable_o, timer1_toggle_out_enable_o;
  logic [3:0] adr_i = 0, sel_i = 4'hF;
  logic [31:0] dat_i = 0, dat_o;
  int err_count = 0, cmp_count = 0;
  timer_run_flags i_timer_run_flags (.*);
  initial forever #50 clk_i = ~clk_i;
  // Reads compare with d; an error answer reads as FF, which no mapped place shows
  task automatic wb(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_i) {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do @(posedge clk_i); while (!ack_o && !err_o);
    if (!w) cmp_count++;
    if (!w && (err_o ? 32'hFF : dat_o) !== {24'h0, d}) begin
      err_count++;
      $display("ERROR %0t read %h", $time, dat_o);
    end
    {cyc_i, stb_i} <= 2'b00;
  endtask
  // Pin copies lag the register by one cycle, so wait two edges
  task automatic pins(input logic [5:0] e);
    @(posedge clk_i);
    @(posedge clk_i);
    cmp_count++;
    if ({timer1_overflow_flag_o, timer1_run_o, timer0_overflow_flag_o, timer0_run_o, timer1_toggle_out_enable_o,
         timer0_toggle_out_enable_o} !== e) begin
      err_count++;
      $display("ERROR %0t pins %b", $time, e);
    end
  endtask
  task automatic ev(input logic [2:0] p);
    @(posedge clk_i) {timer0_vector_i, timer1_overflow_i, timer0_overflow_i} <= p;
    @(posedge clk_i) {timer0_vector_i, timer1_overflow_i, timer0_overflow_i} <= 3'b0;
  endtask
  task automatic t_run;
    wb(4'h0, 8'h5F, 1); wb(4'h0, 8'h50, 0);
    pins(6'b010100);
  endtask
  task automatic t_flag;
    ev(3'b011); wb(4'h0, 8'hF0, 0);
    pins(6'b111100);
    ev(3'b100); wb(4'h0, 8'hD0, 0);
    pins(6'b110100);
    ev(3'b001); wb(4'h0, 8'hD0, 1); wb(4'h0, 8'hD0, 0);
    pins(6'b110100);
  endtask
  task automatic t_mask;
    wb(4'h0, 8'h00, 1); wb(4'h4, 8'h05, 1); ev(3'b011); wb(4'h0, 8'h00, 0);
    wb(4'h4, 8'h05, 0); wb(4'h8, 8'hFF, 0);
    pins(6'b000011);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin repeat (4) @(posedge clk_i); rst_i <= 0; t_run; t_flag; t_mask; close_out; end
  initial begin #50000; err_count++; close_out; end
endmodule
